// >>> cso_pkg.sv
// Package: constants, register map and carriers for the clock sync block
package cso_pkg;

   // Register bus geometry
   localparam int CSO_AW = 8;
   localparam int CSO_DW = 32;

   // Register byte offsets
   localparam logic [7:0] CSO_OFF_CTRL = 8'h00;
   localparam logic [7:0] CSO_OFF_BUSY = 8'h04;
   localparam logic [7:0] CSO_OFF_CFG = 8'h08;
   localparam logic [7:0] CSO_OFF_STAT = 8'h0C;

   // Control and busy field positions
   localparam int CSO_BIT_SOFT_RESET_REQUEST = 0;
   localparam int CSO_BIT_ENABLE = 1;

   // Clock chain configuration field positions
   localparam int CSO_BIT_SRC_EN = 0;
   localparam int CSO_BIT_ONDEMAND = 1;
   localparam int CSO_BIT_GEN_EN = 2;
   localparam int CSO_BIT_CH_EN = 3;

   // Status field positions
   localparam int CSO_BIT_CORE_EN = 0;
   localparam int CSO_BIT_CLK_REQ = 1;
   localparam int CSO_BIT_SRC_RUN = 2;
   localparam int CSO_BIT_PEND = 3;
   localparam int CSO_BIT_CHAIN_OK = 4;

   // Reset values
   localparam logic [3:0] CSO_CFG_RST = 4'h0;

   // Bus clock period and generic clock divider
   localparam int CSO_CLK_NS = 10;
   localparam int CSO_GENERIC_CLOCK_UNIT_NS = 40;
   localparam int CSO_GENERIC_CLOCK_UNIT_DIV = CSO_GENERIC_CLOCK_UNIT_NS / CSO_CLK_NS;
   localparam logic [7:0] CSO_GENERIC_CLOCK_UNIT_DIV_M1 = 8'(CSO_GENERIC_CLOCK_UNIT_DIV - 1);

   // Sync delay: six generic edges then two bus stages
   localparam logic [3:0] CSO_SYNC_TICKS = 4'h6;
   localparam logic [1:0] CSO_SYNC_STAGES = 2'h2;
   localparam int CSO_OTHER_REQ = 4;

   // Control and busy word carrier
   typedef struct packed {
      logic enable;
      logic soft_reset_request;
   } cso_ctrl_t;

   // Clock chain configuration carrier
   typedef struct packed {
      logic ch_en;
      logic gen_en;
      logic ondemand;
      logic src_en;
   } cso_cfg_t;

endpackage : cso_pkg

// >>> cso_tick_gen.sv
// Generic clock tick divider running off the bus clock
`timescale 1ns/1ps
module cso_tick_gen
   import cso_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic run,
   output logic tick
);

   logic [7:0] cnt_ff;
   logic tick_ff;

   // Count bus cycles, one tick pulse per generic period while running
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_ff <= 8'h00;
         tick_ff <= 1'b0;
      end else if (!run) begin
         cnt_ff <= 8'h00;
         tick_ff <= 1'b0;
      end else if (cnt_ff == CSO_GENERIC_CLOCK_UNIT_DIV_M1) begin
         cnt_ff <= 8'h00;
         tick_ff <= 1'b1;
      end else begin
         cnt_ff <= cnt_ff + 8'h01;
         tick_ff <= 1'b0;
      end
   end

   assign tick = tick_ff;

endmodule : cso_tick_gen

// >>> cso_sync_ctr.sv
// One write-synchronization channel toward the generic clock domain
`timescale 1ns/1ps
module cso_sync_ctr
   import cso_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic start,
   input wire logic tick,
   output logic done
);

   typedef enum logic [3:0] {
      CSO_SY_IDLE = 4'h1,
      CSO_SY_TICK = 4'h2,
      CSO_SY_SETTLE = 4'h4,
      CSO_SY_DONE = 4'h8
   } cso_sy_state_t;

   cso_sy_state_t state_ff;
   logic [3:0] tick_cnt_ff;
   logic [1:0] stage_cnt_ff;

   // Wait for six generic edges, then two bus stages back to bus side;
   // the sixth edge cycle is the first stage, so the upper bound is met
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= CSO_SY_IDLE;
         tick_cnt_ff <= 4'h0;
         stage_cnt_ff <= 2'h0;
      end else begin
         case (state_ff)
            CSO_SY_IDLE: begin
               tick_cnt_ff <= 4'h0;
               stage_cnt_ff <= 2'h0;
               if (start) begin
                  state_ff <= CSO_SY_TICK;
               end
            end
            CSO_SY_TICK: begin
               if (tick) begin
                  tick_cnt_ff <= tick_cnt_ff + 4'h1;
                  if (tick_cnt_ff + 4'h1 == CSO_SYNC_TICKS) begin
                     stage_cnt_ff <= 2'h1;
                     state_ff <= CSO_SY_SETTLE;
                  end
               end
            end
            CSO_SY_SETTLE: begin
               stage_cnt_ff <= stage_cnt_ff + 2'h1;
               if (stage_cnt_ff + 2'h1 == CSO_SYNC_STAGES) begin
                  state_ff <= CSO_SY_DONE;
               end
            end
            CSO_SY_DONE: begin
               state_ff <= CSO_SY_IDLE;
            end
            default: begin
               state_ff <= CSO_SY_IDLE;
            end
         endcase
      end
   end

   assign done = (state_ff == CSO_SY_DONE);

endmodule : cso_sync_ctr

// >>> cso_clock_sync.sv
// Top: register sync for enable and soft reset, on-demand clock request
`timescale 1ns/1ps
// What this block does
// - Writing soft reset one starts sync, sets busy
// - Soft reset bit reads one right away
// - Reset done clears soft reset and busy
// - Writing soft reset zero does nothing
// - Enable busy holds until enable sync ends
// - Sync delay between 5G+2B and 6G+3B
// - Plain register access takes two bus cycles
// - Masked interface reads zero, drops writes
// - Generic clock needs source, generator, channel
// - On-demand source stops when nobody requests
// - Any request starts or keeps an enabled source running
// - Last request withdrawn stops the source
// - Request passes only with generator and channel enabled
module cso_clock_sync
   import cso_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [CSO_AW-1:0] addr,
   input wire logic [CSO_DW-1:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [CSO_DW-1:0] rdata,
   input wire logic pm_unmask,
   input wire logic core_req,
   input wire logic [CSO_OTHER_REQ-1:0] other_req,
   output logic core_en,
   output logic core_reset,
   output logic clk_req,
   output logic src_run,
   output logic generic_clock_unit_tick
);

   // Register state
   cso_ctrl_t ctrl_ff;
   cso_ctrl_t busy_ff;
   cso_ctrl_t pend_data_ff;
   cso_cfg_t cfg_ff;
   logic pend_ff;
   logic core_en_ff;
   logic core_reset_ff;
   logic clk_req_ff;
   logic src_run_ff;
   logic generic_clock_unit_tick_ff;
   logic [CSO_DW-1:0] rdata_ff;

   // Decoded accesses and sync handshake
   logic wr_ok;
   logic rd_ok;
   logic wr_ctrl;
   logic wr_cfg;
   logic any_busy;
   logic apply;
   cso_ctrl_t apply_data;
   logic start_soft_reset_request;
   logic start_enable;
   logic done_soft_reset_request;
   logic done_enable;
   logic tick;
   logic chain_ok;
   logic my_req;
   logic nxt_clk_req;
   logic nxt_src_run;
   logic [CSO_DW-1:0] nxt_rdata;

   // Masked interface drops every access
   assign wr_ok = wr_stb & pm_unmask;
   assign rd_ok = rd_stb & pm_unmask;
   assign wr_ctrl = wr_ok & (addr == CSO_OFF_CTRL);
   assign wr_cfg = wr_ok & (addr == CSO_OFF_CFG);
   assign any_busy = busy_ff.enable | busy_ff.soft_reset_request;

   // A control write lands now only with no sync in flight
   always_comb begin
      apply = 1'b0;
      apply_data = '0;
      if (!any_busy && pend_ff) begin
         apply = 1'b1;
         apply_data = pend_data_ff;
      end else if (!any_busy && wr_ctrl) begin
         apply = 1'b1;
         apply_data.soft_reset_request = wdata[CSO_BIT_SOFT_RESET_REQUEST];
         apply_data.enable = wdata[CSO_BIT_ENABLE];
      end
   end

   // Soft reset wins over an enable carried in the same word
   assign start_soft_reset_request = apply & apply_data.soft_reset_request;
   assign start_enable = apply & !apply_data.soft_reset_request;

   // Hold one control write back while a sync is running
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pend_ff <= 1'b0;
         pend_data_ff <= '0;
      end else if (done_soft_reset_request) begin
         pend_ff <= 1'b0;
      end else if (wr_ctrl && (any_busy || pend_ff)) begin
         pend_ff <= 1'b1;
         pend_data_ff.soft_reset_request <= wdata[CSO_BIT_SOFT_RESET_REQUEST];
         pend_data_ff.enable <= wdata[CSO_BIT_ENABLE];
      end else if (apply) begin
         pend_ff <= 1'b0;
      end
   end

   // Control bits as software sees them
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_ff <= '0;
      end else if (done_soft_reset_request) begin
         ctrl_ff <= '0;
      end else if (start_soft_reset_request) begin
         ctrl_ff.soft_reset_request <= 1'b1;
      end else if (start_enable) begin
         ctrl_ff.enable <= apply_data.enable;
      end
   end

   // Busy flags: set by a launched sync, cleared by hardware on done
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_ff <= '0;
      end else begin
         if (start_soft_reset_request) begin
            busy_ff.soft_reset_request <= 1'b1;
         end else if (done_soft_reset_request) begin
            busy_ff.soft_reset_request <= 1'b0;
         end
         if (start_enable) begin
            busy_ff.enable <= 1'b1;
         end else if (done_enable || done_soft_reset_request) begin
            busy_ff.enable <= 1'b0;
         end
      end
   end

   // Enable as seen by the generic clock side, after sync
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         core_en_ff <= 1'b0;
      end else if (done_soft_reset_request) begin
         core_en_ff <= 1'b0;
      end else if (done_enable) begin
         core_en_ff <= ctrl_ff.enable;
      end
   end

   // One-cycle reset pulse into the peripheral core
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         core_reset_ff <= 1'b0;
      end else begin
         core_reset_ff <= done_soft_reset_request;
      end
   end

   // Clock chain configuration, plain register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_ff <= cso_cfg_t'(CSO_CFG_RST);
      end else if (wr_cfg) begin
         cfg_ff.src_en <= wdata[CSO_BIT_SRC_EN];
         cfg_ff.ondemand <= wdata[CSO_BIT_ONDEMAND];
         cfg_ff.gen_en <= wdata[CSO_BIT_GEN_EN];
         cfg_ff.ch_en <= wdata[CSO_BIT_CH_EN];
      end
   end

   // Generic clock reaches the core only through the full chain
   assign chain_ok = src_run_ff & cfg_ff.gen_en & cfg_ff.ch_en;

   // Own request: core asks while enabled, or a sync needs edges
   assign my_req = (core_req & core_en_ff) | any_busy;

   // Request passes the channel and generator gates to the source
   always_comb begin
      nxt_clk_req = 1'b0;
      if (cfg_ff.gen_en && cfg_ff.ch_en) begin
         nxt_clk_req = my_req;
      end
   end

   // Source with src_en set runs always, or on demand while any request stands
   always_comb begin
      nxt_src_run = 1'b0;
      if (!cfg_ff.src_en) begin
         nxt_src_run = 1'b0;
      end else if (!cfg_ff.ondemand) begin
         nxt_src_run = 1'b1;
      end else if (nxt_clk_req || (|other_req)) begin
         nxt_src_run = 1'b1;
      end else begin
         nxt_src_run = 1'b0;
      end
   end

   // Request and source state flops
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         clk_req_ff <= 1'b0;
         src_run_ff <= 1'b0;
      end else begin
         clk_req_ff <= nxt_clk_req;
         src_run_ff <= nxt_src_run;
      end
   end

   // Generic clock edges, only while the chain is up
   cso_tick_gen u_tick (
      .clk(clk),
      .rst_b(rst_b),
      .run(chain_ok),
      .tick(tick)
   );

   // Soft reset sync channel
   cso_sync_ctr u_sync_soft_reset_request (
      .clk(clk),
      .rst_b(rst_b),
      .start(start_soft_reset_request),
      .tick(tick),
      .done(done_soft_reset_request)
   );

   // Enable sync channel
   cso_sync_ctr u_sync_enable (
      .clk(clk),
      .rst_b(rst_b),
      .start(start_enable),
      .tick(tick),
      .done(done_enable)
   );

   // Registered copy of the generic edge for the core
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         generic_clock_unit_tick_ff <= 1'b0;
      end else begin
         generic_clock_unit_tick_ff <= tick;
      end
   end

   // Read mux; unmapped or masked reads give zero
   always_comb begin
      nxt_rdata = '0;
      if (rd_ok) begin
         case (addr)
            CSO_OFF_CTRL: begin
               nxt_rdata[CSO_BIT_SOFT_RESET_REQUEST] = ctrl_ff.soft_reset_request;
               nxt_rdata[CSO_BIT_ENABLE] = ctrl_ff.enable;
            end
            CSO_OFF_BUSY: begin
               nxt_rdata[CSO_BIT_SOFT_RESET_REQUEST] = busy_ff.soft_reset_request;
               nxt_rdata[CSO_BIT_ENABLE] = busy_ff.enable;
            end
            CSO_OFF_CFG: begin
               nxt_rdata[CSO_BIT_SRC_EN] = cfg_ff.src_en;
               nxt_rdata[CSO_BIT_ONDEMAND] = cfg_ff.ondemand;
               nxt_rdata[CSO_BIT_GEN_EN] = cfg_ff.gen_en;
               nxt_rdata[CSO_BIT_CH_EN] = cfg_ff.ch_en;
            end
            CSO_OFF_STAT: begin
               nxt_rdata[CSO_BIT_CORE_EN] = core_en_ff;
               nxt_rdata[CSO_BIT_CLK_REQ] = clk_req_ff;
               nxt_rdata[CSO_BIT_SRC_RUN] = src_run_ff;
               nxt_rdata[CSO_BIT_PEND] = pend_ff;
               nxt_rdata[CSO_BIT_CHAIN_OK] = chain_ok;
            end
            default: begin
               nxt_rdata = '0;
            end
         endcase
      end
   end

   // Read data stands in the cycle after the strobe only
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign rdata = rdata_ff;
   assign core_en = core_en_ff;
   assign core_reset = core_reset_ff;
   assign clk_req = clk_req_ff;
   assign src_run = src_run_ff;
   assign generic_clock_unit_tick = generic_clock_unit_tick_ff;

endmodule : cso_clock_sync

// >>> cso_clock_sync_properties.sv
// Concurrent checks on the clock sync block ports
`timescale 1ns/1ps
module cso_clock_sync_properties
   import cso_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [CSO_AW-1:0] addr,
   input wire logic [CSO_DW-1:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [CSO_DW-1:0] rdata,
   input wire logic pm_unmask,
   input wire logic core_req,
   input wire logic [CSO_OTHER_REQ-1:0] other_req,
   input wire logic core_en,
   input wire logic core_reset,
   input wire logic clk_req,
   input wire logic src_run,
   input wire logic generic_clock_unit_tick
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   // Read data stands only in the answer cycle
   a_rdata_idle_zero: assert property (!rd_stb |=> rdata == '0)
      else $error("read data not zero outside answer cycle");
   a_masked_read_zero: assert property (rd_stb && !pm_unmask |=> rdata == '0)
      else $error("masked read returned data");
   a_unmapped_zero: assert property (rd_stb && addr > CSO_OFF_STAT |=> rdata == '0)
      else $error("unmapped read returned data");
   // Status word mirrors the live outputs at the strobe
   a_stat_mirrors: assert property (rd_stb && pm_unmask && addr == CSO_OFF_STAT
      |=> rdata[2:0] == {$past(src_run), $past(clk_req), $past(core_en)})
      else $error("status word differs from outputs");
   // Soft reset completion
   a_reset_pulse_one: assert property (core_reset |=> !core_reset)
      else $error("core reset longer than one cycle");
   a_reset_drops_en: assert property (core_reset |-> !core_en)
      else $error("enable survives soft reset");
   // Generic clock edges are at least four cycles apart and come from a running source
   a_tick_spacing: assert property (generic_clock_unit_tick |=> !generic_clock_unit_tick [*3])
      else $error("generic ticks closer than four cycles");
   a_tick_needs_src: assert property (generic_clock_unit_tick |-> $past(src_run, 2))
      else $error("tick without running source");

   c_soft_reset: cover property (core_reset);
   c_enable: cover property ($rose(core_en));
   c_src_stop: cover property ($fell(src_run));
endmodule : cso_clock_sync_properties

bind cso_clock_sync cso_clock_sync_properties u_props (.clk(clk),
   .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
   .rd_stb(rd_stb), .rdata(rdata), .pm_unmask(pm_unmask),
   .core_req(core_req), .other_req(other_req), .core_en(core_en),
   .core_reset(core_reset), .clk_req(clk_req), .src_run(src_run),
   .generic_clock_unit_tick(generic_clock_unit_tick));

// >>> cso_core_model.sv
// Peripheral core model that asks for its generic clock
`timescale 1ns/1ps
module cso_core_model (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic core_en,
   input wire logic want,
   output logic core_req
);
   // Ask for the clock only while enabled and holding work
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         core_req <= 1'b0;
      end else begin
         core_req <= core_en & want;
      end
   end
endmodule : cso_core_model

// >>> cso_clock_sync_tb.sv
// Self-checking testbench for the clock sync block
`timescale 1ns/1ps
module cso_clock_sync_tb
   import cso_pkg::*;
;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [CSO_AW-1:0] addr = '0;
   logic [CSO_DW-1:0] wdata = '0;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic pm_unmask = 1'b1;
   logic want = 1'b0;
   logic [CSO_OTHER_REQ-1:0] other_req = '0;
   logic [CSO_DW-1:0] rdata, rv;
   logic core_req, core_en, core_reset, clk_req, src_run, generic_clock_unit_tick;
   int miscompares = 0;
   int cmp_count = 0;
   int cyc = 0;
   int sw_delay = 0;

   cso_clock_sync dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .pm_unmask(pm_unmask),
      .core_req(core_req), .other_req(other_req), .core_en(core_en),
      .core_reset(core_reset), .clk_req(clk_req), .src_run(src_run),
      .generic_clock_unit_tick(generic_clock_unit_tick));
   cso_core_model u_core (.clk(clk), .rst_b(rst_b), .core_en(core_en),
      .want(want), .core_req(core_req));

   // Bus clock
   initial begin
      forever #5 clk = ~clk;
   end

   // Edges from a soft reset write to the core reset pulse
   always @(posedge clk) begin
      cyc <= (wr_stb && addr == CSO_OFF_CTRL && wdata[0]) ? 0 : cyc + 1;
      if (core_reset === 1'b1) sw_delay <= cyc;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic print_verdict;
      if (miscompares == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : print_verdict

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1 d = rdata;
   endtask : rd

   // Poll busy flags and pending write, bounded
   task automatic wait_idle;
      for (int n = 0; n < 100; n++) begin
         rd(CSO_OFF_BUSY, rv);
         if (rv[1:0] === 2'b00) begin
            rd(CSO_OFF_STAT, rv);
            if (rv[CSO_BIT_PEND] === 1'b0) return;
         end
      end
      miscompares++;
      print_verdict();
   endtask : wait_idle

   // Expected {clk_req, src_run} with the core enabled
   function automatic logic [1:0] exp_clk(input logic [3:0] c, input logic w,
      input logic [3:0] o);
      logic rq;
      rq = c[CSO_BIT_GEN_EN] & c[CSO_BIT_CH_EN] & w;
      return {rq, c[CSO_BIT_SRC_EN] & (!c[CSO_BIT_ONDEMAND] | rq | (|o))};
   endfunction : exp_clk

   initial begin
      logic [3:0] cfg;
      logic w;
      logic [3:0] o;
      void'($urandom(76418));
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      // Reset values, unmapped word included
      for (int i = 0; i < 5; i++) begin
         rd(8'(i * 4), rv);
         chk(rv, 32'h0);
      end
      wr(CSO_OFF_CFG, 32'hF);
      rd(CSO_OFF_CFG, rv);
      chk(rv, 32'hF);
      // Soft reset with the source free-running, so start-up is excluded
      wr(CSO_OFF_CFG, 32'hD);
      repeat (8) @(posedge clk);
      wr(CSO_OFF_CTRL, 32'h1);
      rd(CSO_OFF_CTRL, rv);
      chk(rv & 32'h1, 32'h1);
      rd(CSO_OFF_BUSY, rv);
      chk(rv & 32'h1, 32'h1);
      wait_idle();
      chk(32'((sw_delay > 22) && (sw_delay < 27)), 32'h1);
      rd(CSO_OFF_CTRL, rv);
      chk(rv, 32'h0);
      wr(CSO_OFF_CFG, 32'hF);
      wr(CSO_OFF_CTRL, 32'h0);
      rd(CSO_OFF_BUSY, rv);
      chk(rv & 32'h1, 32'h0);
      wait_idle();
      // Enable sync with a pending write behind it
      want <= 1'b1;
      wr(CSO_OFF_CTRL, 32'h2);
      rd(CSO_OFF_BUSY, rv);
      chk(rv & 32'h3, 32'h2);
      chk(32'(core_en), 32'h0);
      wr(CSO_OFF_CTRL, 32'h0);
      rd(CSO_OFF_STAT, rv);
      chk(rv & 32'h8, 32'h8);
      wr(CSO_OFF_CTRL, 32'h2);
      wait_idle();
      chk(32'(core_en), 32'h1);
      // Masked interface
      @(posedge clk);
      pm_unmask <= 1'b0;
      wr(CSO_OFF_CFG, 32'h0);
      rd(CSO_OFF_CFG, rv);
      chk(rv, 32'h0);
      @(posedge clk);
      pm_unmask <= 1'b1;
      rd(CSO_OFF_CFG, rv);
      chk(rv, 32'hF);
      // On-demand requests: corners first, then random
      for (int i = 0; i < 30; i++) begin
         cfg = 4'($urandom);
         w = 1'($urandom);
         o = 4'($urandom);
         case (i)
            0: {cfg, w, o} = {4'hF, 1'b0, 4'h0};
            1: {cfg, w, o} = {4'hB, 1'b1, 4'h0};
            2: {cfg, w, o} = {4'hF, 1'b1, 4'h0};
            3: {cfg, w, o} = {4'h3, 1'b0, 4'h4};
            default: ;
         endcase
         wr(CSO_OFF_CFG, 32'(cfg));
         want <= w;
         other_req <= o;
         repeat (5) @(posedge clk);
         #1 chk(32'({clk_req, src_run}), 32'(exp_clk(cfg, w, o)));
      end
      print_verdict();
   end
endmodule : cso_clock_sync_tb
